// File: common/halt_power_pkg.sv
// Constants, types and carriers shared by the halt-mode power controller
package halt_power_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses on the word-wide bus)
    localparam int          ADDR_W           = 4;
    localparam logic [3:0]  REG_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  REG_STATUS_OFS   = 4'h4;
    localparam logic [3:0]  REG_WAKE_OFS     = 4'h8;

    // Field positions
    localparam int          CTRL_OIE_BIT     = 0;
    localparam int          STATUS_STATE_LSB = 0;
    localparam int          STATUS_LONG_BIT  = 8;
    localparam int          STATUS_WDGOPT_BIT = 9;
    localparam int          STATUS_STALL_BIT = 10;
    localparam int          WAKE_RESET_BIT   = 6;

    // Reset values
    localparam logic        CTRL_OIE_RESET   = 1'b0;
    localparam logic [6:0]  WAKE_SRC_RESET   = 7'h00;
    localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counts, in CPU cycles (one CPU cycle is one clk_sys cycle)
    localparam int          DELAY_SHORT_CYC  = 256;
    localparam int          DELAY_LONG_CYC   = 4096;
    localparam int          CNT_W            = 13;

    // Core interface constants
    localparam logic [7:0]  HALT_OPCODE      = 8'h8E;
    localparam logic [1:0]  CC_MASK_HALT     = 2'h2;

    // Wake-capable sources, in priority order
    localparam int          WAKE_N           = 6;
    localparam int          IRQ_IDX_W        = 3;
    localparam int          WAKE_TIME_BASE   = 0;
    localparam int          WAKE_EXT0        = 1;
    localparam int          WAKE_EXT1        = 2;
    localparam int          WAKE_EXT2        = 3;
    localparam int          WAKE_EXT3        = 4;
    localparam int          WAKE_SPI         = 5;

    ////////////////////////////////////////////////////////////////////////////
    // States, one-hot
    typedef enum logic [5:0] {
        ST_RUN        = 6'b000001,
        ST_ACT_HALT   = 6'b000010,
        ST_HALT       = 6'b000100,
        ST_OSC_WAIT   = 6'b001000,
        ST_GUARD      = 6'b010000,
        ST_GUARD_HALT = 6'b100000
    } power_state_t;

    // Clock gating to the rest of the chip
    typedef struct packed {
        logic osc_run;
        logic time_base_run;
        logic periph_run;
    } clk_gate_t;

    // Commands to the CPU core
    typedef struct packed {
        logic                 stall;
        logic                 fetch_reset;
        logic                 service_irq;
        logic [IRQ_IDX_W-1:0] irq_index;
        logic                 push_cc;
        logic                 cc_load;
        logic [1:0]           cc_level;
        logic                 wdg_reset_req;
    } core_ctrl_t;

endpackage : halt_power_pkg

// File: hw/startup_counter.sv
// Start-up delay counter: counts a selected number of cycles after a start pulse
`timescale 1ns/1ps
`default_nettype none
module startup_counter #(
    parameter int SHORT_CYC = halt_power_pkg::DELAY_SHORT_CYC,
    parameter int LONG_CYC  = halt_power_pkg::DELAY_LONG_CYC,
    parameter int W         = halt_power_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Control
    input  wire logic start,
    input  wire logic sel_long,
    // Status
    output logic      busy,
    output logic      done
);
    import halt_power_pkg::*;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         busy_reg;
    logic         busy_next;
    logic         done_reg;
    logic         done_next;
    wire  [W-1:0] load_val = sel_long ? W'(LONG_CYC - 1) : W'(SHORT_CYC - 1);
    wire          last     = busy_reg && (cnt_reg == '0);

    // A new start restarts the count even when one is running
    assign cnt_next  = start ? load_val : (busy_reg && !last) ? cnt_reg - W'(1) : cnt_reg;
    assign busy_next = start | (busy_reg & ~last);
    assign done_next = last & ~start;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : startup_counter
`default_nettype wire

// File: hw/halt_mode_power_controller.sv
// Halt and active-halt power controller with its register slave
`timescale 1ns/1ps
`default_nettype none
module halt_mode_power_controller #(
    parameter int SHORT_CYC = halt_power_pkg::DELAY_SHORT_CYC,
    parameter int LONG_CYC  = halt_power_pkg::DELAY_LONG_CYC
) (
    // Clock and reset
    input  wire logic                               clk_sys,
    input  wire logic                               rst,
    // Avalon-MM slave
    input  wire logic [halt_power_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                               avs_read,
    input  wire logic                               avs_write,
    input  wire logic [31:0]                        avs_writedata,
    output logic      [31:0]                        avs_readdata,
    output logic                                    avs_waitrequest,
    // CPU core
    input  wire logic                               opcode_exec,
    input  wire logic [7:0]                         opcode,
    input  wire logic [1:0]                         irq_sw_level,
    output halt_power_pkg::core_ctrl_t              core_ctrl,
    // Wake sources and watchdog
    input  wire logic [halt_power_pkg::WAKE_N-1:0]  wake_irq,
    input  wire logic                               wake_reset,
    input  wire logic                               watchdog_active,
    // Option straps
    input  wire logic                               delay_long_option,
    input  wire logic                               watchdog_halt_option,
    // Clock gating
    output halt_power_pkg::clk_gate_t               clk_gate
);
    import halt_power_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and option capture

    logic wake_reset_meta;
    logic wake_reset_sync;
    logic opt_long_meta;
    logic opt_long_sync;
    logic opt_wdg_meta;
    logic opt_wdg_sync;

    always_ff @(posedge clk_sys) begin
        wake_reset_meta <= wake_reset;
        wake_reset_sync <= wake_reset_meta;
        opt_long_meta   <= delay_long_option;
        opt_long_sync   <= opt_long_meta;
        opt_wdg_meta    <= watchdog_halt_option;
        opt_wdg_sync    <= opt_wdg_meta;
    end

    // Straps are non-volatile; taken once after reset release
    logic capture_reg;
    logic opt_long_reg;
    logic opt_wdg_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capture_reg  <= 1'b1;
            opt_long_reg <= 1'b0;
            opt_wdg_reg  <= 1'b0;
        end else if (capture_reg) begin
            capture_reg  <= 1'b0;
            opt_long_reg <= opt_long_sync;
            opt_wdg_reg  <= opt_wdg_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register slave

    logic        ack_reg;
    logic        oie_reg;
    logic        oie_next;
    logic [31:0] rdata_reg;
    logic [6:0]  wake_src_reg;
    logic [6:0]  wake_src_next;

    // One wait cycle, then the answer
    wire         bus_req   = avs_read | avs_write;
    wire         wr_commit = avs_write & ack_reg;
    wire         rd_load   = avs_read & ~ack_reg;
    wire         sel_ctrl  = (avs_address == REG_CTRL_OFS);
    wire         sel_stat  = (avs_address == REG_STATUS_OFS);
    wire         sel_wake  = (avs_address == REG_WAKE_OFS);

    power_state_t state_reg;
    power_state_t state_next;
    logic         cnt_busy;
    logic         cnt_done;

    wire  [31:0] ctrl_word = {31'h0000_0000, oie_reg};
    wire  [31:0] stat_word = {21'h00_0000, core_ctrl.stall, opt_wdg_reg, opt_long_reg, 2'h0, state_reg};
    wire  [31:0] wake_word = {25'h000_0000, wake_src_reg};
    wire  [31:0] rd_mux;

    // Unmapped addresses read zero and ignore writes
    assign rd_mux = sel_ctrl ? ctrl_word :
                    sel_stat ? stat_word :
                    sel_wake ? wake_word : 32'h0000_0000;

    assign oie_next = (wr_commit && sel_ctrl) ? avs_writedata[CTRL_OIE_BIT] : oie_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            oie_reg   <= CTRL_OIE_RESET;
            rdata_reg <= RDATA_RESET;
        end else begin
            ack_reg   <= bus_req & ~ack_reg;
            oie_reg   <= oie_next;
            if (rd_load) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = bus_req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Wake decode

    // Lowest index is highest priority among the wake lines
    logic [IRQ_IDX_W-1:0] wake_idx;
    always_comb begin
        wake_idx = '0;
        for (int i = WAKE_N - 1; i >= 0; i--) begin
            if (wake_irq[i]) begin
                wake_idx = IRQ_IDX_W'(i);
            end
        end
    end

    // Timer, async serial and voltage-detector requests are not wired in at all
    wire any_wake  = |wake_irq;
    wire halt_exec = opcode_exec && (opcode == HALT_OPCODE);
    // Watchdog option low: halt with OIE clear and an active watchdog resets instead
    wire wdg_trip  = halt_exec && !oie_reg && watchdog_active && !opt_wdg_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine

    logic                 pend_reset_reg;
    logic                 pend_reset_next;
    logic [IRQ_IDX_W-1:0] pend_idx_reg;
    logic [IRQ_IDX_W-1:0] pend_idx_next;
    logic                 cnt_start;
    logic                 fetch_now;
    logic                 service_now;
    logic [IRQ_IDX_W-1:0] service_idx;
    logic                 mask_force;

    always_comb begin
        state_next      = state_reg;
        pend_reset_next = pend_reset_reg;
        pend_idx_next   = pend_idx_reg;
        wake_src_next   = wake_src_reg;
        cnt_start       = 1'b0;
        fetch_now       = 1'b0;
        service_now     = 1'b0;
        service_idx     = wake_idx;
        mask_force      = 1'b0;
        case (state_reg)
            ST_RUN, ST_GUARD: begin
                if (wake_reset_sync) begin
                    fetch_now  = 1'b1;
                    state_next = ST_RUN;
                end else if (halt_exec && !wdg_trip) begin
                    mask_force = 1'b1;
                    state_next = oie_reg ? ST_ACT_HALT : ST_HALT;
                end else if (state_reg == ST_GUARD && cnt_done) begin
                    state_next = ST_RUN;
                end else if (state_reg == ST_GUARD && !oie_reg) begin
                    state_next = ST_GUARD_HALT;
                end
            end
            ST_ACT_HALT: begin
                if (wake_reset_sync) begin
                    wake_src_next   = 7'(1 << WAKE_RESET_BIT);
                    pend_reset_next = 1'b1;
                    cnt_start       = 1'b1;
                    state_next      = ST_OSC_WAIT;
                end else if (any_wake) begin
                    wake_src_next = 7'(wake_irq);
                    service_now   = 1'b1;
                    cnt_start     = 1'b1;
                    state_next    = ST_GUARD;
                end
            end
            ST_HALT: begin
                if (wake_reset_sync || any_wake) begin
                    wake_src_next   = wake_reset_sync ? 7'(1 << WAKE_RESET_BIT) : 7'(wake_irq);
                    pend_reset_next = wake_reset_sync;
                    pend_idx_next   = wake_idx;
                    cnt_start       = 1'b1;
                    state_next      = ST_OSC_WAIT;
                end
            end
            ST_OSC_WAIT: begin
                if (wake_reset_sync && !pend_reset_reg) begin
                    pend_reset_next = 1'b1;
                    cnt_start       = 1'b1;
                end else if (cnt_done) begin
                    fetch_now   = pend_reset_reg;
                    service_now = !pend_reset_reg;
                    service_idx = pend_idx_reg;
                    state_next  = ST_RUN;
                end
            end
            ST_GUARD_HALT: begin
                if (wake_reset_sync) begin
                    pend_reset_next = 1'b1;
                    cnt_start       = 1'b1;
                    state_next      = ST_OSC_WAIT;
                end else if (cnt_done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (state_next == ST_RUN) begin
            pend_reset_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg      <= ST_RUN;
            pend_reset_reg <= 1'b0;
            pend_idx_reg   <= '0;
            wake_src_reg   <= WAKE_SRC_RESET;
        end else begin
            state_reg      <= state_next;
            pend_reset_reg <= pend_reset_next;
            pend_idx_reg   <= pend_idx_next;
            wake_src_reg   <= wake_src_next;
        end
    end

    startup_counter #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC),
        .W         (CNT_W)
    ) u_delay (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .start     (cnt_start),
        .sel_long  (opt_long_reg),
        .busy      (cnt_busy),
        .done      (cnt_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    core_ctrl_t core_reg;
    core_ctrl_t core_next;
    clk_gate_t  gate_reg;
    clk_gate_t  gate_next;

    wire run_like  = (state_next == ST_RUN) || (state_next == ST_GUARD);
    wire osc_off   = (state_next == ST_HALT) || (state_next == ST_GUARD_HALT);

    // Gates follow the next state so they switch with the state itself
    assign gate_next.osc_run       = !osc_off;
    assign gate_next.time_base_run = !osc_off;
    assign gate_next.periph_run    = run_like;

    assign core_next.stall         = !run_like;
    assign core_next.fetch_reset   = fetch_now;
    assign core_next.service_irq   = service_now;
    assign core_next.irq_index     = service_now ? service_idx : core_reg.irq_index;
    assign core_next.push_cc       = service_now;
    assign core_next.cc_load       = service_now | mask_force;
    assign core_next.cc_level      = mask_force ? CC_MASK_HALT : irq_sw_level;
    assign core_next.wdg_reset_req = wdg_trip;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_reg <= '0;
            gate_reg <= '{osc_run: 1'b1, time_base_run: 1'b1, periph_run: 1'b1};
        end else begin
            core_reg <= core_next;
            gate_reg <= gate_next;
        end
    end

    assign core_ctrl = core_reg;
    assign clk_gate  = gate_reg;

endmodule : halt_mode_power_controller
`default_nettype wire

// File: bench/halt_mode_power_controller_chk.sv
// Port-level assertions for the halt-mode power controller
`timescale 1ns/1ps
`default_nettype none
module halt_mode_power_controller_chk
    import halt_power_pkg::*;
#(
    parameter int SHORT_CYC = 8,
    parameter int LONG_CYC  = 16
) (
    // Clock and reset
    input wire logic                       clk_sys,
    input wire logic                       rst,
    // Bus
    input wire logic                       avs_read,
    input wire logic                       avs_waitrequest,
    // Core and wake side
    input wire logic                       opcode_exec,
    input wire logic [7:0]                 opcode,
    input wire logic                       wake_reset,
    input wire logic                       watchdog_active,
    input wire logic                       watchdog_halt_option,
    input wire halt_power_pkg::core_ctrl_t core_ctrl,
    input wire halt_power_pkg::clk_gate_t  clk_gate
);
    // Longest stall after the oscillator restarts, with slack for the exit steps
    localparam int OSC_END_MAX = LONG_CYC + 8;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_entry_mask;
        core_ctrl.cc_load && !core_ctrl.service_irq |-> core_ctrl.cc_level == CC_MASK_HALT;
    endproperty
    a_entry_mask: assert property (p_entry_mask) else $error("mask level not 10b on entry");
    property p_service_push;
        core_ctrl.service_irq |-> core_ctrl.push_cc && core_ctrl.cc_load;
    endproperty
    a_service_push: assert property (p_service_push) else $error("service without flag push");
    property p_halt_take;
        opcode_exec && opcode == HALT_OPCODE && !core_ctrl.stall |=> core_ctrl.stall || core_ctrl.wdg_reset_req;
    endproperty
    a_halt_take: assert property (p_halt_take) else $error("halt opcode not taken");
    property p_other_op;
        opcode_exec && opcode != HALT_OPCODE |=> !(core_ctrl.cc_load && !core_ctrl.service_irq);
    endproperty
    a_other_op: assert property (p_other_op) else $error("other opcode entered halt");
    property p_osc_off;
        !clk_gate.osc_run |-> !clk_gate.periph_run && !clk_gate.time_base_run;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("clocks run with oscillator off");
    property p_gate_stall;
        !clk_gate.periph_run |-> core_ctrl.stall;
    endproperty
    a_gate_stall: assert property (p_gate_stall) else $error("core runs with peripherals gated");
    property p_osc_end;
        $rose(clk_gate.osc_run) |-> ##[1:OSC_END_MAX] !core_ctrl.stall;
    endproperty
    a_osc_end: assert property (p_osc_end) else $error("stall outlasts start-up count");
    property p_wdg;
        core_ctrl.wdg_reset_req |-> $past(watchdog_active) && !watchdog_halt_option;
    endproperty
    a_wdg: assert property (p_wdg) else $error("watchdog reset without cause");
    property p_reset_wake;
        $rose(wake_reset) |-> ##[2:OSC_END_MAX] core_ctrl.fetch_reset;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("no reset vector fetch");
    property p_bus_wait;
        $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("read wait not one cycle");
    c_service: cover property (core_ctrl.service_irq);
    c_fetch: cover property (core_ctrl.fetch_reset);
    c_wdg: cover property (core_ctrl.wdg_reset_req);
endmodule : halt_mode_power_controller_chk
bind halt_mode_power_controller halt_mode_power_controller_chk #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC (LONG_CYC)
) chk_inst (
    .clk_sys             (clk_sys),
    .rst                 (rst),
    .avs_read            (avs_read),
    .avs_waitrequest     (avs_waitrequest),
    .opcode_exec         (opcode_exec),
    .opcode              (opcode),
    .wake_reset          (wake_reset),
    .watchdog_active     (watchdog_active),
    .watchdog_halt_option(watchdog_halt_option),
    .core_ctrl           (core_ctrl),
    .clk_gate            (clk_gate)
);
`default_nettype wire

// File: bench/core_model.sv
// Behavioural CPU core that issues opcodes and obeys the controller
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    // Requests from the bench
    input  wire logic                       issue,
    input  wire logic [7:0]                 issue_op,
    // Controller side
    input  wire halt_power_pkg::core_ctrl_t core_ctrl,
    output logic                            opcode_exec,
    output logic [7:0]                      opcode,
    output logic [1:0]                      irq_sw_level
);
    import halt_power_pkg::*;
    // A stalled core fetches nothing; the idle opcode bus toggles, so a stale byte returns every other cycle and only opcode_exec marks a fetch
    always_ff @(posedge clk_sys) begin
        opcode_exec <= issue && !core_ctrl.stall && !rst;
        opcode      <= rst ? 8'h00 : (issue ? issue_op : ~opcode);
        if (rst) begin
            irq_sw_level <= 2'h3;
        end else if (issue) begin
            irq_sw_level <= irq_sw_level + 2'h1;
        end
    end
endmodule : core_model
`default_nettype wire

// File: bench/halt_mode_power_controller_tb.sv
// Self-checking bench for the halt-mode power controller
`timescale 1ns/1ps
`default_nettype none
module halt_mode_power_controller_tb;
    import halt_power_pkg::*;
    localparam int SHORT = 8;
    localparam int LONG  = 16;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] avs_address = 4'h0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              opcode_exec;
    logic [7:0]        opcode;
    logic [1:0]        irq_sw_level;
    core_ctrl_t        core_ctrl;
    clk_gate_t         clk_gate;
    logic [WAKE_N-1:0] wake_irq = 6'h00;
    logic              wake_reset = 1'b0;
    logic              watchdog_active = 1'b0;
    logic              delay_long_option = 1'b0;
    logic              watchdog_halt_option = 1'b1;
    logic              issue = 1'b0;
    logic [7:0]        issue_op = 8'h00;
    logic [31:0]       rd;
    int                err_total = 0;
    int                n_compared = 0;
    int                n;
    int                idx;
    always #5 clk_sys = ~clk_sys;
    halt_mode_power_controller #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) halt_mode_power_controller_inst (
        .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .opcode_exec(opcode_exec), .opcode(opcode),
        .irq_sw_level(irq_sw_level), .core_ctrl(core_ctrl), .wake_irq(wake_irq), .wake_reset(wake_reset),
        .watchdog_active(watchdog_active), .delay_long_option(delay_long_option),
        .watchdog_halt_option(watchdog_halt_option), .clk_gate(clk_gate));
    core_model core_model_inst (.clk_sys(clk_sys), .rst(rst), .issue(issue), .issue_op(issue_op),
        .core_ctrl(core_ctrl), .opcode_exec(opcode_exec), .opcode(opcode), .irq_sw_level(irq_sw_level));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic end_of_test(input logic timed_out);
        if (timed_out) err_total++;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Request held until waitrequest is sampled low; no latency assumed
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n == 50) end_of_test(1'b1);
    endtask : bus
    // Counts cycles until a service pulse (0), a reset fetch (1) or a released stall (2)
    task automatic wait_sig(input int sel);
        for (n = 1; n < 200; n++) begin
            @(posedge clk_sys);
            #1;
            if (sel == 0 && core_ctrl.service_irq === 1'b1) break;
            if (sel == 1 && core_ctrl.fetch_reset === 1'b1) break;
            if (sel == 2 && core_ctrl.stall === 1'b0) break;
        end
        if (n == 200) end_of_test(1'b1);
    endtask : wait_sig
    task automatic run_op(input logic [7:0] op);
        @(posedge clk_sys);
        issue    <= 1'b1;
        issue_op <= op;
        @(posedge clk_sys);
        issue <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : run_op
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h3D2B));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, REG_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, REG_STATUS_OFS, 32'hFFFF_FFFF);
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_0201);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 12; i++) begin
            idx = i % WAKE_N;
            bus(1'b1, REG_CTRL_OFS, {31'h0, i >= 6});
            run_op(HALT_OPCODE ^ 8'($urandom_range(1, 255)));
            chk(core_ctrl.stall, 1'b0);
            run_op(HALT_OPCODE);
            chk({core_ctrl.stall, core_ctrl.cc_load, core_ctrl.cc_level}, 4'hE);
            chk(clk_gate, (i >= 6) ? 3'b110 : 3'b000);
            repeat ($urandom_range(1, 20)) @(posedge clk_sys);
            wake_irq[idx] <= 1'b1;
            wait_sig(0);
            chk(core_ctrl.irq_index, idx[2:0]);
            chk(core_ctrl.cc_level, irq_sw_level);
            if (i >= 6) chk(n <= 2, 1'b1);
            else chk(n >= SHORT && n <= SHORT + 6, 1'b1);
            wake_irq <= 6'h00;
            repeat (LONG + 4) @(posedge clk_sys);
        end
        wake_irq[WAKE_EXT0] <= 1'b1;
        run_op(HALT_OPCODE);
        wait_sig(0);
        chk(n <= 3, 1'b1);
        wake_irq <= 6'h00;
        repeat (LONG + 4) @(posedge clk_sys);
        // Enable dropped inside the guard period: oscillator stops until the count ends
        run_op(HALT_OPCODE);
        wake_irq[WAKE_SPI] <= 1'b1;
        wait_sig(0);
        wake_irq <= 6'h00;
        bus(1'b1, REG_CTRL_OFS, 32'h0);
        @(posedge clk_sys);
        #1;
        chk({clk_gate.osc_run, core_ctrl.stall}, 2'b01);
        wait_sig(2);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, REG_CTRL_OFS, 32'(j));
            run_op(HALT_OPCODE);
            wake_reset <= 1'b1;
            repeat (4) @(posedge clk_sys);
            wake_reset <= 1'b0;
            wait_sig(1);
            chk(n + 4 >= SHORT, 1'b1);
            bus(1'b0, REG_WAKE_OFS, 32'h0);
            chk(rd, 32'h0000_0040);
            repeat (LONG + 4) @(posedge clk_sys);
        end
        rst                  <= 1'b1;
        delay_long_option    <= 1'b1;
        watchdog_halt_option <= 1'b0;
        watchdog_active      <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, REG_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_0101);
        run_op(HALT_OPCODE);
        chk(core_ctrl.wdg_reset_req, 1'b1);
        repeat (LONG + 4) @(posedge clk_sys);
        bus(1'b1, REG_CTRL_OFS, 32'h1);
        run_op(HALT_OPCODE);
        chk({core_ctrl.wdg_reset_req, core_ctrl.stall}, 2'b01);
        wake_irq[WAKE_TIME_BASE] <= 1'b1;
        wait_sig(0);
        wake_irq <= 6'h00;
        repeat (LONG + 4) @(posedge clk_sys);
        watchdog_active <= 1'b0;
        bus(1'b1, REG_CTRL_OFS, 32'h0);
        run_op(HALT_OPCODE);
        wake_irq[WAKE_EXT3] <= 1'b1;
        wait_sig(0);
        chk(n >= LONG && n <= LONG + 6, 1'b1);
        wake_irq <= 6'h00;
        bus(1'b0, REG_WAKE_OFS, 32'h0);
        chk(rd, 32'h0000_0010);
        end_of_test(1'b0);
    end
endmodule : halt_mode_power_controller_tb
`default_nettype wire
